// ---- core/circ_addr.sv ----
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "circ_consts.svh"
module circ_addr (
  input  wire logic          aclk,          // Core clock
  input  wire logic          aresetn,       // Synchronous reset, active low
  input  wire logic [11:0]   s_axi_awaddr,  // Write address
  input  wire logic          s_axi_awvalid, // Write address valid
  output logic               s_axi_awready, // Write address ready
  input  wire logic [31:0]   s_axi_wdata,   // Write data
  input  wire logic [3:0]    s_axi_wstrb,   // Byte strobes
  input  wire logic          s_axi_wvalid,  // Write data valid
  output logic               s_axi_wready,  // Write data ready
  output logic [1:0]         s_axi_bresp,   // Write response
  output logic               s_axi_bvalid,  // Write response valid
  input  wire logic          s_axi_bready,  // Write response ready
  input  wire logic [11:0]   s_axi_araddr,  // Read address
  input  wire logic          s_axi_arvalid, // Read address valid
  output logic               s_axi_arready, // Read address ready
  output logic [31:0]        s_axi_rdata,   // Read data
  output logic [1:0]         s_axi_rresp,   // Read response
  output logic               s_axi_rvalid,  // Read response valid
  input  wire logic          s_axi_rready,  // Read response ready
  input  wire logic          xr_valid,      // X read generator update
  input  wire circ_pkg::sel_t xr_ptr,       // X read pointer register number
  input  wire circ_pkg::addr_t xr_base,     // X read pointer value
  input  wire circ_pkg::addr_t xr_step,     // X read step in bytes
  output circ_pkg::addr_t    xr_next,       // X read updated pointer
  input  wire logic          xw_valid,      // X write generator update
  input  wire circ_pkg::sel_t xw_ptr,       // X write pointer register number
  input  wire circ_pkg::addr_t xw_base,     // X write pointer value
  input  wire circ_pkg::addr_t xw_step,     // X write step in bytes
  output circ_pkg::addr_t    xw_next,       // X write updated pointer
  input  wire logic          y_valid,       // Y generator update
  input  wire circ_pkg::sel_t y_ptr,        // Y pointer register number
  input  wire circ_pkg::addr_t y_base,      // Y pointer value
  input  wire circ_pkg::addr_t y_step,      // Y step in bytes
  output circ_pkg::addr_t    y_next,        // Y updated pointer
  output logic               x_active,      // X circular mode on
  output logic               y_active       // Y circular mode on
);
  logic [15:0]     circular_addr_control;
  circ_pkg::addr_t x_buffer_start;
  circ_pkg::addr_t x_buffer_end;
  circ_pkg::addr_t y_buffer_start;
  circ_pkg::addr_t y_buffer_end;
  circ_pkg::sel_t  x_pointer_select;
  circ_pkg::sel_t  y_pointer_select;
  logic            x_circular_enable;
  logic            y_circular_enable;
  logic            aw_held_reg;
  logic            w_held_reg;
  logic [11:0]     aw_addr_reg;
  logic [31:0]     w_data_reg;
  logic [3:0]      w_strb_reg;
  logic            wr_go;
  logic            wr_hit;
  logic            rd_hit;
  logic [31:0]     rd_word;
  logic            xr_on;
  logic            xw_on;
  logic            y_on;
  circ_pkg::addr_t xr_calc;
  circ_pkg::addr_t xw_calc;
  circ_pkg::addr_t y_calc;

  assign x_pointer_select  = circular_addr_control[`X_SEL_LSB +: 4];
  assign y_pointer_select  = circular_addr_control[`Y_SEL_LSB +: 4];
  assign x_circular_enable = circular_addr_control[`X_EN_BIT];
  assign y_circular_enable = circular_addr_control[`Y_EN_BIT];
  // Select 1111 shuts off both X generators at once
  assign x_active = x_circular_enable && (x_pointer_select != `SEL_DISABLED);
  assign y_active = y_circular_enable && (y_pointer_select != `SEL_DISABLED);

  // Only the selected pointer wraps; frame/stack pointer choice is left to software
  assign xr_on = x_active && (xr_ptr == x_pointer_select);
  assign xw_on = x_active && (xw_ptr == x_pointer_select);
  assign y_on  = y_active && (y_ptr == y_pointer_select);

  // Separate bound sets keep the X and Y buffers independent; direction use is software's
  circ_wrap u_xr (
    .word_only(1'b0),
    .active   (xr_on),
    .base     (xr_base),
    .step     (xr_step),
    .start    (x_buffer_start),
    .fin      (x_buffer_end),
    .next     (xr_calc)
  );
  circ_wrap u_xw (
    .word_only(1'b0),
    .active   (xw_on),
    .base     (xw_base),
    .step     (xw_step),
    .start    (x_buffer_start),
    .fin      (x_buffer_end),
    .next     (xw_calc)
  );
  circ_wrap u_y (
    .word_only(1'b1),
    .active   (y_on),
    .base     (y_base),
    .step     (y_step),
    .start    (y_buffer_start),
    .fin      (y_buffer_end),
    .next     (y_calc)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xr_next <= `BOUND_RESET;
      xw_next <= `BOUND_RESET;
      y_next  <= `BOUND_RESET;
    end else begin
      if (xr_valid)
        xr_next <= xr_calc;
      if (xw_valid)
        xw_next <= xw_calc;
      if (y_valid)
        y_next <= y_calc;
    end
  end

  // AXI write: address and data taken in either order, response after both
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign wr_go         = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    case (aw_addr_reg)
      `CTRL_OFFSET, `X_START_OFFSET, `X_END_OFFSET,
      `Y_START_OFFSET, `Y_END_OFFSET: wr_hit = 1'b1;
      default:                        wr_hit = 1'b0;
    endcase
  end

  // 16-bit registers; only the two low byte lanes matter
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      circular_addr_control <= `CTRL_RESET;
      x_buffer_start <= `BOUND_RESET;
      x_buffer_end   <= `BOUND_RESET;
      y_buffer_start <= `BOUND_RESET;
      y_buffer_end   <= `BOUND_RESET;
    end else if (wr_go) begin
      case (aw_addr_reg)
        `CTRL_OFFSET:    circular_addr_control <=
                           merge(circular_addr_control, w_data_reg, w_strb_reg);
        `X_START_OFFSET: x_buffer_start <= merge(x_buffer_start, w_data_reg, w_strb_reg);
        `X_END_OFFSET:   x_buffer_end   <= merge(x_buffer_end, w_data_reg, w_strb_reg);
        `Y_START_OFFSET: y_buffer_start <= merge(y_buffer_start, w_data_reg, w_strb_reg);
        `Y_END_OFFSET:   y_buffer_end   <= merge(y_buffer_end, w_data_reg, w_strb_reg);
        default: ;
      endcase
    end
  end

  // AXI read: one outstanding, data registered
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      `CTRL_OFFSET:    rd_word = {16'h0000, circular_addr_control};
      `X_START_OFFSET: rd_word = {16'h0000, x_buffer_start};
      `X_END_OFFSET:   rd_word = {16'h0000, x_buffer_end};
      `Y_START_OFFSET: rd_word = {16'h0000, y_buffer_start};
      `Y_END_OFFSET:   rd_word = {16'h0000, y_buffer_end};
      default:         rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Space enables and pointer selection
  a_x_disable: assert property (@(posedge aclk) disable iff (!aresetn)
    (x_pointer_select == `SEL_DISABLED) |-> !x_active)
    else $error("X active with select 1111");

  a_y_disable: assert property (@(posedge aclk) disable iff (!aresetn)
    (y_pointer_select == `SEL_DISABLED) |-> !y_active)
    else $error("Y active with select 1111");

  a_x_off_both: assert property (@(posedge aclk) disable iff (!aresetn)
    (x_pointer_select == `SEL_DISABLED) |-> !xr_on && !xw_on)
    else $error("X generator on with select 1111");

  a_x_enable_bit: assert property (@(posedge aclk) disable iff (!aresetn)
    x_active == (circular_addr_control[15] && circular_addr_control[3:0] != 4'hF))
    else $error("X active mismatch");

  a_y_enable_bit: assert property (@(posedge aclk) disable iff (!aresetn)
    y_active == (circular_addr_control[14] && circular_addr_control[7:4] != 4'hF))
    else $error("Y active mismatch");

  a_reset_state: assert property (@(posedge aclk)
    $rose(aresetn) |-> circular_addr_control == `CTRL_RESET && !x_active && !y_active)
    else $error("Control not at reset value");

  // Pointer updates
  a_y_word_align: assert property (@(posedge aclk) disable iff (!aresetn)
    y_valid |=> !y_next[0])
    else $error("Y pointer odd");

  a_xr_bypass: assert property (@(posedge aclk) disable iff (!aresetn)
    (xr_valid && !xr_on) |=> xr_next == $past(xr_base + xr_step))
    else $error("X read changed while off");

  a_xw_bypass: assert property (@(posedge aclk) disable iff (!aresetn)
    (xw_valid && !xw_on) |=> xw_next == $past(xw_base + xw_step))
    else $error("X write changed while off");

  a_y_bypass: assert property (@(posedge aclk) disable iff (!aresetn)
    (y_valid && !y_on) |=> y_next == $past((y_base + y_step) & 16'hFFFE))
    else $error("Y changed while off");

  a_xr_in_range: assert property (@(posedge aclk) disable iff (!aresetn)
    (xr_valid && xr_on && xr_base >= x_buffer_start && xr_base <= x_buffer_end
     && x_buffer_start <= x_buffer_end) ##1 $stable(x_buffer_start) && $stable(x_buffer_end)
    |-> xr_next >= x_buffer_start && xr_next <= x_buffer_end)
    else $error("X read left buffer");

  a_xw_in_range: assert property (@(posedge aclk) disable iff (!aresetn)
    (xw_valid && xw_on && xw_base >= x_buffer_start && xw_base <= x_buffer_end
     && x_buffer_start <= x_buffer_end) ##1 $stable(x_buffer_start) && $stable(x_buffer_end)
    |-> xw_next >= x_buffer_start && xw_next <= x_buffer_end)
    else $error("X write left buffer");

  a_y_in_range: assert property (@(posedge aclk) disable iff (!aresetn)
    (y_valid && y_on && y_base >= y_buffer_start && y_base <= y_buffer_end
     && y_buffer_start < y_buffer_end)
    ##1 $stable(y_buffer_start) && $stable(y_buffer_end)
    |-> y_next[15:1] >= y_buffer_start[15:1] && y_next <= y_buffer_end)
    else $error("Y left buffer");

  a_xr_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !xr_valid |=> $stable(xr_next))
    else $error("X read pointer moved without request");

  a_xw_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !xw_valid |=> $stable(xw_next))
    else $error("X write pointer moved without request");

  a_y_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !y_valid |=> $stable(y_next))
    else $error("Y pointer moved without request");

  // Register writes
  a_bound_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && aw_addr_reg == `X_START_OFFSET && w_strb_reg[1:0] == 2'b11)
    |=> x_buffer_start == $past(w_data_reg[15:0]))
    else $error("Start not written");

  a_y_end_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && aw_addr_reg == `Y_END_OFFSET && w_strb_reg[1:0] == 2'b11)
    |=> y_buffer_end == $past(w_data_reg[15:0]))
    else $error("Y end not written");

  a_ctrl_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && aw_addr_reg == `CTRL_OFFSET && w_strb_reg[1:0] == 2'b11)
    |=> circular_addr_control == $past(w_data_reg[15:0]))
    else $error("Control not written");

  a_bad_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && !wr_hit) |=> s_axi_bresp == `RESP_SLVERR && $stable(circular_addr_control)
     && $stable(x_buffer_start) && $stable(x_buffer_end) && $stable(y_buffer_start)
     && $stable(y_buffer_end))
    else $error("Unmapped write not refused");

  // Register bus handshakes
  a_b_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go |=> s_axi_bvalid)
    else $error("Write response missing");

  a_b_stands: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped");

  a_aw_refused: assert property (@(posedge aclk) disable iff (!aresetn)
    (aw_held_reg || s_axi_bvalid) |-> !s_axi_awready)
    else $error("Write address taken while busy");

  a_w_refused: assert property (@(posedge aclk) disable iff (!aresetn)
    (w_held_reg || s_axi_bvalid) |-> !s_axi_wready)
    else $error("Write data taken while busy");

  a_r_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("Read response missing");

  a_r_stands: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready)
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("Read response dropped");

  a_ar_refused: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("Read address taken while busy");

  a_bad_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && !rd_hit)
    |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("Unmapped read not refused");

  a_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("Upper read half not zero");
endmodule : circ_addr

// ---- core/circ_consts.svh ----
`ifndef CIRC_CONSTS_SVH
`define CIRC_CONSTS_SVH
`define CTRL_OFFSET      12'h000
`define X_START_OFFSET   12'h004
`define X_END_OFFSET     12'h008
`define Y_START_OFFSET   12'h00C
`define Y_END_OFFSET     12'h010
`define X_SEL_LSB        0
`define Y_SEL_LSB        4
`define X_EN_BIT         15
`define Y_EN_BIT         14
`define SEL_DISABLED     4'hF
`define CTRL_RESET       16'h00FF
`define BOUND_RESET      16'h0000
`define MAX_LEN_BYTES    17'h1_0000
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10
`endif

// ---- core/circ_pkg.sv ----
package circ_pkg;
  typedef logic [15:0] addr_t;
  typedef logic [3:0]  sel_t;
endpackage : circ_pkg

// ---- core/circ_wrap.sv ----
`timescale 1ns/1ps
`include "circ_consts.svh"
module circ_wrap (
  input  wire logic          word_only,  // Force low address bit clear
  input  wire logic          active,     // Circular mode on for this pointer
  input  wire circ_pkg::addr_t base,     // Pointer before update
  input  wire circ_pkg::addr_t step,     // Signed step in bytes
  input  wire circ_pkg::addr_t start,    // Buffer start
  input  wire circ_pkg::addr_t fin,      // Buffer end
  output circ_pkg::addr_t      next      // Pointer after update
);
  logic [16:0] sum;
  logic        down;
  circ_pkg::addr_t raw;
  circ_pkg::addr_t s_e;
  circ_pkg::addr_t e_e;
  always_comb begin
    sum  = {1'b0, base} + {1'b0, step};
    down = step[15];
    raw  = sum[15:0];
    s_e  = start;
    e_e  = fin;
    if (word_only) begin
      raw[0] = 1'b0;
      s_e[0] = 1'b0;
      // The last word owns both its bytes, so every wrap lands on an even address
      e_e[0] = 1'b1;
    end
    next = raw;
    // Upward steps check only the end bound, downward steps only the start; full 16-bit span covers 64 Kbytes
    if (active) begin
      if (!down && (raw > e_e || (sum[16] && base <= e_e)))
        next = s_e + (raw - e_e) - 16'h0001;
      else if (down && (raw < s_e || (!sum[16] && base >= s_e)))
        next = e_e - (s_e - raw) + 16'h0001;
    end
  end
endmodule : circ_wrap

// ---- tb/agu_model.sv ----
`timescale 1ns/1ps
module agu_model (
  input  wire logic            aclk,  // Core clock
  input  wire logic            go,    // Issue one update next cycle
  input  wire circ_pkg::sel_t  p_in,  // Pointer number to present
  input  wire circ_pkg::addr_t b_in,  // Pointer value to present
  input  wire circ_pkg::addr_t s_in,  // Step to present
  output logic                 valid, // Update request
  output circ_pkg::sel_t       ptr,   // Pointer number
  output circ_pkg::addr_t      base,  // Pointer value
  output circ_pkg::addr_t      step   // Step in bytes
);
  // Callers step both ways in each buffer; pointer numbers are passed on as given
  always_ff @(posedge aclk) begin
    valid <= go;
    if (go) begin
      ptr  <= p_in;
      base <= b_in;
      step <= s_in;
    end else begin
      // Stale values are scrambled so a late sample cannot match by luck
      ptr  <= ~ptr;
      base <= ~base;
      step <= ~step;
    end
  end
endmodule : agu_model

// ---- tb/circular_buffer_addressing_test.sv ----
`timescale 1ns/1ps
`include "circ_consts.svh"
module circular_buffer_addressing_test;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [2:0]  go, pend, vv;
  circ_pkg::sel_t  pp [3], pt [3];
  circ_pkg::addr_t bb [3], ss [3], bs [3], st [3];
  circ_pkg::addr_t xr_next, xw_next, y_next;
  logic x_active, y_active;
  int bad_count, n_checks;

  for (genvar i = 0; i < 3; i++) begin : g_agu
    agu_model u_agu_model (.aclk(aclk), .go(go[i]), .p_in(pp[i]), .b_in(bb[i]),
      .s_in(ss[i]), .valid(vv[i]), .ptr(pt[i]), .base(bs[i]), .step(st[i]));
  end

  circ_addr u_circ_addr (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .xr_valid(vv[0]), .xr_ptr(pt[0]), .xr_base(bs[0]),
    .xr_step(st[0]), .xr_next(xr_next), .xw_valid(vv[1]), .xw_ptr(pt[1]),
    .xw_base(bs[1]), .xw_step(st[1]), .xw_next(xw_next), .y_valid(vv[2]),
    .y_ptr(pt[2]), .y_base(bs[2]), .y_step(st[2]), .y_next(y_next),
    .x_active(x_active), .y_active(y_active));

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", 32'(er), 32'(bresp));
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", e, rdata);
    chk("rresp", 32'(er), 32'(rresp));
  endtask : axi_rd

  task automatic upd(input int i, input circ_pkg::sel_t p, input circ_pkg::addr_t b,
                     input circ_pkg::addr_t s);
    pp[i]   = p;
    bb[i]   = b;
    ss[i]   = s;
    pend[i] = 1'b1;
  endtask : upd

  // Update result is loaded on the same edge that samples the request, two edges after go is set
  task automatic run();
    @(posedge aclk);
    go <= pend;
    @(posedge aclk);
    go <= 3'b000;
    @(posedge aclk);
    #1;
    pend = 3'b000;
  endtask : run

  initial begin
    repeat (5000) @(posedge aclk);
    bad_count++;
    end_of_test();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, go, pend} = '0;
    awaddr = '0;
    araddr = '0;
    wdata  = '0;
    wstrb  = 4'hF;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`CTRL_OFFSET, 32'h0000_00FF, `RESP_OKAY);
    for (int i = 1; i < 5; i++) axi_rd(12'(4 * i), 32'h0000_0000, `RESP_OKAY);
    chk("x_active", 32'h0000_0000, 32'(x_active));
    chk("y_active", 32'h0000_0000, 32'(y_active));
    axi_rd(12'h014, 32'h0000_0000, `RESP_SLVERR);
    axi_wr(12'h014, 32'h0000_1234, `RESP_SLVERR);
    axi_rd(`CTRL_OFFSET, 32'h0000_00FF, `RESP_OKAY);
    axi_wr(`X_START_OFFSET, 32'hABCD_1000, `RESP_OKAY);
    axi_rd(`X_START_OFFSET, 32'h0000_1000, `RESP_OKAY);
    axi_wr(`X_END_OFFSET, 32'h0000_101F, `RESP_OKAY);
    axi_wr(`Y_START_OFFSET, 32'h0000_2000, `RESP_OKAY);
    axi_wr(`Y_END_OFFSET, 32'h0000_203F, `RESP_OKAY);
    axi_rd(`Y_END_OFFSET, 32'h0000_203F, `RESP_OKAY);
    axi_wr(`CTRL_OFFSET, 32'h0000_C0FF, `RESP_OKAY);
    chk("x_active", 32'h0000_0000, 32'(x_active));
    chk("y_active", 32'h0000_0000, 32'(y_active));
    upd(0, 4'hF, 16'h101E, 16'h0002);
    upd(1, 4'hF, 16'h1000, 16'hFFFE);
    upd(2, 4'hF, 16'h203E, 16'h0002);
    run();
    chk("xr_next", 32'h0000_1020, 32'(xr_next));
    chk("xw_next", 32'h0000_0FFE, 32'(xw_next));
    chk("y_next", 32'h0000_2040, 32'(y_next));
    axi_wr(`CTRL_OFFSET, 32'h0000_8053, `RESP_OKAY);
    axi_rd(`CTRL_OFFSET, 32'h0000_8053, `RESP_OKAY);
    chk("x_active", 32'h0000_0001, 32'(x_active));
    chk("y_active", 32'h0000_0000, 32'(y_active));
    axi_wr(`CTRL_OFFSET, 32'h0000_4053, `RESP_OKAY);
    chk("x_active", 32'h0000_0000, 32'(x_active));
    chk("y_active", 32'h0000_0001, 32'(y_active));
    axi_wr(`CTRL_OFFSET, 32'h0000_C053, `RESP_OKAY);
    upd(0, 4'h3, 16'h101E, 16'h0002);
    upd(1, 4'h3, 16'h1000, 16'hFFFE);
    upd(2, 4'h5, 16'h2011, 16'h0002);
    run();
    chk("xr_next", 32'h0000_1000, 32'(xr_next));
    chk("xw_next", 32'h0000_101E, 32'(xw_next));
    chk("y_next", 32'h0000_2012, 32'(y_next));
    upd(0, 4'h4, 16'h101E, 16'h0002);
    upd(2, 4'h5, 16'h203E, 16'h0002);
    run();
    chk("xr_next", 32'h0000_1020, 32'(xr_next));
    chk("y_next", 32'h0000_2000, 32'(y_next));
    upd(2, 4'h5, 16'h2000, 16'hFFFE);
    run();
    chk("y_next", 32'h0000_203E, 32'(y_next));
    // Pointers 0 to 13 each wrap when selected; 14 is not tried and select 15 turns X off
    for (int i = 0; i < 14; i++) begin
      axi_wr(`CTRL_OFFSET, 32'h0000_8000 | 32'(i), `RESP_OKAY);
      upd(0, 4'(i), 16'h101E, 16'h0002);
      run();
      chk("xr_next", 32'h0000_1000, 32'(xr_next));
    end
    axi_wr(`X_START_OFFSET, 32'h0000_0000, `RESP_OKAY);
    axi_wr(`X_END_OFFSET, 32'h0000_FFFF, `RESP_OKAY);
    upd(0, 4'hD, 16'hFFFE, 16'h0002);
    upd(1, 4'hD, 16'h0000, 16'hFFFE);
    run();
    chk("xr_next", 32'h0000_0000, 32'(xr_next));
    chk("xw_next", 32'h0000_FFFE, 32'(xw_next));
    end_of_test();
  end
endmodule : circular_buffer_addressing_test
